// File: asfs_cfg.svh
// constants for the serial audio format and status slice
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
`ifndef ASFS_CFG_SVH
`define ASFS_CFG_SVH
`define ASFS_OFS_FMT 4'h0
`define ASFS_OFS_STAT 4'h4
`define ASFS_OFS_THR 4'h8
`define ASFS_OFS_MASK 4'hC
`define ASFS_OFS_CLR 4'h4
`define ASFS_BIT_LOOP 5
`define ASFS_BIT_NOPLAY 4
`define ASFS_BIT_NOREC 3
`define ASFS_BIT_FRAME 0
`define ASFS_BIT_ROR 6
`define ASFS_BIT_TUR 5
`define ASFS_BIT_RFS 4
`define ASFS_BIT_TFS 3
`define ASFS_BIT_BSY 2
`define ASFS_BIT_RNE 1
`define ASFS_BIT_TNF 0
`define ASFS_RST_FMT 32'h0000_0000
`define ASFS_RST_THR 4'h7
`define ASFS_RST_MASK 8'h00
`define ASFS_SYNC_BCLK 4
`define ASFS_SYNC_CLK 4
`endif

// File: asfs_pkg.sv
// types for the serial audio format and status slice
package asfs_pkg;
  typedef enum logic [1:0] {
    XF_IDLE = 2'b00,
    XF_WAIT = 2'b01,
    XF_HOLD = 2'b11
  } asfs_xfer_t;
  typedef struct packed {
    logic noPlay;
    logic noRec;
    logic frameSel;
  } asfs_ctl_t;
endpackage

// File: asfs_ctl_if.sv
// control word carrier between format register and bit-clock crossing
interface asfs_ctl_if;
  import asfs_pkg::*;
  asfs_ctl_t ctl;
  logic loopback;
  modport src (output ctl, output loopback);
  modport dst (input ctl, input loopback);
endinterface

// File: asfs_fifo_count.sv
// level counter for one sample fifo, with fullness and error events
module asfs_fifo_count
  import asfs_pkg::*;
#(
  parameter int DEPTH = 16
)
(
  // clock
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // strobes
  input wire logic push,
  input wire logic pop,
  // state
  output logic [$clog2(DEPTH):0] level,
  output logic full,
  output logic empty,
  output logic pushFull,
  output logic popEmpty
);
  localparam int LW = $clog2(DEPTH) + 1;
  logic [LW-1:0] lvl_q;
  logic doPush;
  logic doPop;
  assign full = (lvl_q == LW'(DEPTH));
  assign empty = (lvl_q == '0);
  assign doPush = push && !full;
  assign doPop = pop && !empty;
  assign pushFull = push && full;
  assign popEmpty = pop && empty;
  assign level = lvl_q;
  always_ff @(posedge clk)
  begin
    if (srst)
      lvl_q <= '0;
    else if (ce && (doPush != doPop))
      lvl_q <= doPush ? lvl_q + LW'(1) : lvl_q - LW'(1);
  end
endmodule // asfs_fifo_count

// File: audio_serial_format_status.sv
// format control and fifo/link status slice of a serial audio controller
//
// The address map and the Avalon-MM register port were left to the implementer.
`include "asfs_cfg.svh"
module audio_serial_format_status
  import asfs_pkg::*;
#(
  parameter int DEPTH = 16
)
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // fifo side strobes from the data path, and the link enable
  input wire logic txPush,
  input wire logic rxPop,
  input wire logic linkEnable,
  // serial link pins
  input wire logic serialBitClock,
  input wire logic serialIn,
  output logic serialOut,
  // controls delivered in the bit-clock domain, and the interrupt
  output logic noPlay_q,
  output logic noRec_q,
  output logic frameSel_q,
  output logic irq_q
);
  asfs_ctl_if ctlBus ();

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] bclkSync_q;
  logic [1:0] sinSync_q;
  logic bclkPrev_q;
  logic bclkRise;
  logic bclkFall;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bclkSync_q <= 2'b00;
      sinSync_q <= 2'b00;
      bclkPrev_q <= 1'b0;
    end
    else if (ce)
    begin
      bclkSync_q <= {bclkSync_q[0], serialBitClock};
      sinSync_q <= {sinSync_q[0], serialIn};
      bclkPrev_q <= bclkSync_q[1];
    end
  end
  assign bclkRise = bclkSync_q[1] && !bclkPrev_q;
  assign bclkFall = !bclkSync_q[1] && bclkPrev_q;

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic loop_q;
  logic [3:0] rxThr_q;
  logic [7:0] mask_q;
  logic ror_q;
  logic tur_q;
  logic wrClr;
  logic rdPend_q;
  asfs_ctl_t shadow_q;
  // status offset is write-one-to-clear for ROR and TUR; the other status bits ignore the write
  assign wrClr = ce && write && !waitrequest && (address == `ASFS_OFS_CLR);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      loop_q <= 1'b0;
      shadow_q <= '0;
      rxThr_q <= `ASFS_RST_THR;
      mask_q <= `ASFS_RST_MASK;
    end
    else if (ce && write && !waitrequest)
    begin
      case (address)
        `ASFS_OFS_FMT:
        begin
          loop_q <= writedata[`ASFS_BIT_LOOP];
          shadow_q.noPlay <= writedata[`ASFS_BIT_NOPLAY];
          shadow_q.noRec <= writedata[`ASFS_BIT_NOREC];
          shadow_q.frameSel <= writedata[`ASFS_BIT_FRAME];
        end
        `ASFS_OFS_THR: rxThr_q <= writedata[3:0];
        `ASFS_OFS_MASK: mask_q <= writedata[7:0];
        default: ;
      endcase
    end
  end
  assign ctlBus.ctl = shadow_q;
  assign ctlBus.loopback = loop_q;

  // one wait state on every access keeps read data registered
  always_ff @(posedge clk)
  begin
    if (srst)
      rdPend_q <= 1'b0;
    else if (ce)
      rdPend_q <= (read || write) && !rdPend_q;
  end
  always_ff @(posedge clk)
  begin
    if (srst)
      waitrequest <= 1'b1;
    else if (ce)
      waitrequest <= !((read || write) && !rdPend_q && waitrequest);
  end

  // ---------------------------------------------------------------------------
  // crossing into the bit-clock domain
  // ---------------------------------------------------------------------------
  asfs_xfer_t xs_q;
  asfs_ctl_t pend_q;
  asfs_ctl_t outCtl;
  logic [2:0] bcnt_q;
  logic [2:0] ccnt_q;
  logic newVal;
  assign outCtl = {noPlay_q, noRec_q, frameSel_q};
  // compare with what was delivered, so a write on the delivery edge is not lost
  assign newVal = (ctlBus.ctl != outCtl);
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      xs_q <= XF_IDLE;
      pend_q <= '0;
      ccnt_q <= '0;
      bcnt_q <= '0;
      noPlay_q <= 1'b0;
      noRec_q <= 1'b0;
      frameSel_q <= 1'b0;
    end
    else if (ce)
    begin
      case (xs_q)
        XF_IDLE:
          if (newVal)
          begin
            pend_q <= ctlBus.ctl;
            ccnt_q <= '0;
            bcnt_q <= '0;
            xs_q <= XF_WAIT;
          end
        XF_WAIT:
        begin
          // holding register follows the shadow: only the latest write is delivered
          pend_q <= ctlBus.ctl;
          if (ccnt_q == 3'(`ASFS_SYNC_CLK - 1))
            xs_q <= XF_HOLD;
          else
            ccnt_q <= ccnt_q + 3'd1;
        end
        XF_HOLD:
        begin
          pend_q <= ctlBus.ctl;
          if (bclkRise)
          begin
            if (bcnt_q == 3'(`ASFS_SYNC_BCLK - 1))
            begin
              noPlay_q <= pend_q.noPlay;
              noRec_q <= pend_q.noRec;
              frameSel_q <= pend_q.frameSel;
              xs_q <= XF_IDLE;
            end
            else
              bcnt_q <= bcnt_q + 3'd1;
          end
        end
        default: xs_q <= XF_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // link side: one sample per bit-clock fall while enabled
  // ---------------------------------------------------------------------------
  logic linkTx;
  logic linkRx;
  logic rxBit;
  assign linkTx = linkEnable && bclkFall && !noPlay_q;
  assign linkRx = linkEnable && bclkFall && !noRec_q;
  assign rxBit = loop_q ? serialOut : sinSync_q[1];
  logic [$clog2(DEPTH):0] txLvl;
  logic [$clog2(DEPTH):0] rxLvl;
  logic txFull;
  logic txEmpty;
  logic rxFull;
  logic rxEmpty;
  logic rxOver;
  logic txUnder;
  asfs_fifo_count #(.DEPTH(DEPTH)) txCnt (
    .clk(clk), .srst(srst), .ce(ce), .push(txPush), .pop(linkTx),
    .level(txLvl), .full(txFull), .empty(txEmpty), .pushFull(), .popEmpty(txUnder)
  );
  asfs_fifo_count #(.DEPTH(DEPTH)) rxCnt (
    .clk(clk), .srst(srst), .ce(ce), .push(linkRx), .pop(rxPop),
    .level(rxLvl), .full(rxFull), .empty(rxEmpty), .pushFull(rxOver), .popEmpty()
  );
  always_ff @(posedge clk)
  begin
    if (srst)
      serialOut <= 1'b0;
    else if (ce && linkTx)
      serialOut <= !serialOut;
  end

  // ---------------------------------------------------------------------------
  // sticky error flags, set wins over clear
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
      ror_q <= 1'b0;
    else if (ce && rxOver)
      ror_q <= 1'b1;
    else if (wrClr && writedata[`ASFS_BIT_ROR])
      ror_q <= 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (srst)
      tur_q <= 1'b0;
    else if (ce && txUnder)
      tur_q <= 1'b1;
    else if (wrClr && writedata[`ASFS_BIT_TUR])
      tur_q <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // status and read data
  // ---------------------------------------------------------------------------
  logic rx_service_request;
  logic [31:0] stat;
  logic [31:0] rdMux;
  assign rx_service_request = linkEnable && (rxLvl >= ({1'b0, rxThr_q} + 5'd1));
  always_comb
  begin
    stat = '0;
    stat[15:12] = rxLvl[3:0];
    stat[11:8] = txLvl[3:0];
    stat[`ASFS_BIT_ROR] = ror_q;
    stat[`ASFS_BIT_TUR] = tur_q;
    stat[`ASFS_BIT_RFS] = rx_service_request;
    stat[`ASFS_BIT_TNF] = !txFull;
    stat[`ASFS_BIT_RNE] = !rxEmpty;
  end
  always_comb
  begin
    case (address)
      `ASFS_OFS_FMT: rdMux = {26'h0, loop_q, noPlay_q, noRec_q, 2'b00, frameSel_q};
      `ASFS_OFS_STAT: rdMux = stat;
      `ASFS_OFS_THR: rdMux = {28'h0, rxThr_q};
      `ASFS_OFS_MASK: rdMux = {24'h0, mask_q};
      default: rdMux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (srst)
      readdata <= '0;
    else if (ce && read && waitrequest && !rdPend_q)
      readdata <= rdMux;
  end
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_q <= 1'b0;
    else if (ce)
      irq_q <= (ror_q && mask_q[`ASFS_BIT_ROR]) || (tur_q && mask_q[`ASFS_BIT_TUR])
        || (rx_service_request && mask_q[`ASFS_BIT_RFS]);
  end
endmodule // audio_serial_format_status

// File: audio_serial_format_status_monitor.sv
// port-level assertions for the format and status slice
module asfs_monitor
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register bus
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // crossed controls
  input wire logic noPlay_q,
  input wire logic noRec_q,
  input wire logic frameSel_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_fmt_wr;
    write && !waitrequest && address == 4'h0;
  endsequence
  sequence s_stat_rd;
    read && !waitrequest && address == 4'h4;
  endsequence
  property p_ans;
    (read || write) |-> ##[0:2] !waitrequest;
  endproperty
  property p_once;
    !waitrequest |=> waitrequest;
  endproperty
  property p_idle;
    !read && !write && !$past(read) && !$past(write) |-> waitrequest;
  endproperty
  property p_rst;
    $fell(srst) |-> waitrequest && !noPlay_q && !noRec_q && !frameSel_q;
  endproperty
  // the crossing needs four bit clocks, so nothing can move within four cycles
  property p_hold;
    s_fmt_wr |=> $stable({noPlay_q, noRec_q, frameSel_q}) [*4];
  endproperty
  property p_rsvd;
    s_stat_rd |-> readdata[31:16] == 16'h0000 && !readdata[7];
  endproperty
  property p_rne;
    s_stat_rd and readdata[15:12] != 4'h0 |-> readdata[1];
  endproperty
  property p_tnf;
    s_stat_rd and readdata[11:8] != 4'h0 |-> readdata[0];
  endproperty
  property p_full;
    s_stat_rd and !readdata[0] |-> readdata[11:8] == 4'h0;
  endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  a_once: assert property (p_once) else $error("answer longer than one cycle");
  a_idle: assert property (p_idle) else $error("answer without request");
  a_rst: assert property (p_rst) else $error("outputs wrong after reset");
  a_hold: assert property (p_hold) else $error("control crossed too early");
  a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
  a_rne: assert property (p_rne) else $error("rx level without not-empty");
  a_tnf: assert property (p_tnf) else $error("tx level but flagged full");
  a_full: assert property (p_full) else $error("tx full with nonzero field");
endmodule // asfs_monitor

bind audio_serial_format_status asfs_monitor u_mon (.clk(clk), .srst(srst),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .noPlay_q(noPlay_q), .noRec_q(noRec_q),
  .frameSel_q(frameSel_q));

// File: asfs_codec_model.sv
// behavioural codec driving bit clock and sample data into the link
module asfs_codec_model
(
  // bench control
  input wire logic run,
  // link pins
  output logic bitClock,
  output logic dataOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pat = 16'hA5C3;
  // clock stands still while run is low; data keeps moving so no stale level is read
  initial
  begin
    bitClock = 1'b0;
    dataOut = 1'b1;
    forever
    begin
      #80;
      if (run)
      begin
        bitClock = ~bitClock;
        if (!bitClock)
        begin
          pat = {pat[14:0], pat[15] ^ pat[13]};
          dataOut = pat[0];
        end
      end
      else
      begin
        bitClock = 1'b0;
        dataOut = ~dataOut;
      end
    end
  end
endmodule // asfs_codec_model

// File: audio_serial_format_status_tb_top.sv
// self-checking bench for the format and status slice
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errorCnt++; \
  $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module audio_serial_format_status_tb_top
  import asfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [4:0] push; logic [31:0] stat;} asfs_row_t;
  asfs_row_t rows [4] = '{'{5'd0, 32'h0000_0001}, '{5'd1, 32'h0000_0101},
    '{5'd14, 32'h0000_0F01}, '{5'd1, 32'h0000_0000}};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic txPush = 1'b0;
  logic rxPop = 1'b0;
  logic linkEnable = 1'b0;
  logic run = 1'b0;
  logic serialBitClock, serialIn, serialOut, noPlay_q, noRec_q, frameSel_q, irq_q;
  logic waitrequest;
  logic [31:0] readdata;
  logic [31:0] rd;
  int errorCnt = 0;
  int nTests = 0;
  int cyc = 0;
  audio_serial_format_status #(.DEPTH(16)) dut (.clk, .srst, .ce, .address, .read,
    .write, .writedata, .readdata, .waitrequest, .txPush, .rxPop, .linkEnable,
    .serialBitClock, .serialIn, .serialOut, .noPlay_q, .noRec_q, .frameSel_q, .irq_q);
  asfs_codec_model codec (.run(run), .bitClock(serialBitClock), .dataOut(serialIn));
  always #10 clk = ~clk;
  // ------------------------------------------------------------
  // bus and fifo helpers
  // ------------------------------------------------------------
  task automatic busOp(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic pulseFifo(input logic tx, input int n);
    repeat (n)
    begin
      @(posedge clk);
      if (tx) txPush <= 1'b1; else rxPop <= 1'b1;
      @(posedge clk);
      txPush <= 1'b0;
      rxPop <= 1'b0;
    end
  endtask
  task automatic waitCtl(input logic [2:0] e);
    int k;
    k = 0;
    while ({noPlay_q, noRec_q, frameSel_q} !== e && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    `CHK({noPlay_q, noRec_q, frameSel_q}, e)
  endtask
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // a hung poll ends here; full run needs well under this
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      errorCnt++;
      wrapUp();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    busOp(1'b0, 4'h0, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    `CHK(serialOut, 1'b0)
    busOp(1'b0, 4'h8, 32'h0000_0000);
    `CHK(rd, 32'h0000_0007)
    for (int i = 0; i < 4; i++)
    begin
      pulseFifo(1'b1, int'(rows[i].push));
      busOp(1'b0, 4'h4, 32'h0000_0000);
      `CHK(rd & 32'hFFFF_FFF3, rows[i].stat)
    end
    busOp(1'b1, 4'h4, 32'hFFFF_FFFF);
    busOp(1'b0, 4'h4, 32'h0000_0000);
    `CHK(rd & 32'hFFFF_FFF3, 32'h0000_0000)
    run <= 1'b1;
    busOp(1'b1, 4'h0, 32'h0000_0039);
    waitCtl(3'b111);
    // format readback shows the delivered controls, so read after the crossing
    busOp(1'b0, 4'h0, 32'h0000_0000);
    `CHK(rd, 32'h0000_0039)
    // two writes inside one crossing interval: only the later survives
    busOp(1'b1, 4'h0, 32'h0000_0010);
    busOp(1'b1, 4'h0, 32'h0000_0008);
    // the first value must never show; the timeout bounds this wait
    while ({noPlay_q, noRec_q, frameSel_q} === 3'b111)
      @(posedge clk);
    `CHK({noPlay_q, noRec_q, frameSel_q}, 3'b010)
    busOp(1'b1, 4'h0, 32'h0000_0000);
    waitCtl(3'b000);
    linkEnable <= 1'b1;
    rd = 32'h0000_0000;
    while ((rd & 32'h0000_0060) != 32'h0000_0060)
      busOp(1'b0, 4'h4, 32'h0000_0000);
    `CHK(rd[15:12], 4'h0)
    `CHK(rd[1], 1'b1)
    `CHK(rd[4], 1'b1)
    `CHK(irq_q, 1'b0)
    busOp(1'b1, 4'h0, 32'h0000_0018);
    waitCtl(3'b110);
    busOp(1'b1, 4'h4, 32'h0000_0040);
    busOp(1'b0, 4'h4, 32'h0000_0000);
    `CHK(rd[6:5], 2'b01)
    busOp(1'b1, 4'h4, 32'h0000_0020);
    busOp(1'b0, 4'h4, 32'h0000_0000);
    `CHK(rd[6:5], 2'b00)
    pulseFifo(1'b0, 8);
    busOp(1'b0, 4'h4, 32'h0000_0000);
    `CHK({rd[15:12], rd[4]}, 5'b1000_1)
    busOp(1'b1, 4'hC, 32'h0000_0010);
    repeat (2) @(posedge clk);
    `CHK(irq_q, 1'b1)
    pulseFifo(1'b0, 1);
    busOp(1'b0, 4'h4, 32'h0000_0000);
    `CHK({rd[15:12], rd[4]}, 5'b0111_0)
    `CHK(irq_q, 1'b0)
    wrapUp();
  end
endmodule // audio_serial_format_status_tb_top
